// ### src/adc_result_pkg.sv
package adc_result_pkg;
    // register indices as printed; byte address is four times the index
    localparam logic [7:0] IDX_CONTROL = 8'h10;
    localparam logic [7:0] IDX_IRQ_CLEAR = 8'h14;
    localparam logic [7:0] IDX_IRQ_ENABLE = 8'h15;
    localparam logic [7:0] IDX_IRQ_FLAGS = 8'h18;
    localparam logic [7:0] IDX_SYNC_STATUS = 8'h19;
    localparam logic [7:0] IDX_CONVERSION_RESULT = 8'h1a;
    localparam logic [7:0] IDX_WINDOW_LOWER = 8'h1c;
    localparam logic [7:0] IDX_WINDOW_UPPER = 8'h20;
    localparam logic [7:0] IDX_GAIN_FACTOR = 8'h24;
    localparam logic [7:0] IDX_OFFSET_VALUE = 8'h26;
    localparam logic [7:0] IDX_ANALOG_TRIM = 8'h28;
    // control register fields
    localparam int CTL_LEFT_ALIGN = 0;
    localparam int CTL_CORR_EN = 1;
    localparam int CTL_WIN_EN = 2;
    localparam int CTL_OVERSAMPLE = 3;
    // interrupt bits
    localparam int IRQ_RESULT_READY_FLAG = 0;
    localparam int IRQ_OVERRUN = 1;
    localparam int IRQ_WINDOW = 2;
    localparam int IRQ_SYNC = 3;
    localparam int IRQ_BITS = 4;
    localparam int SYNC_BUSY_BIT = 7;
    localparam int GAIN_FRAC_BITS = 11;
    localparam logic [15:0] RESET_VALUE_16 = 16'h0000;
    localparam logic [10:0] TRIM_MASK = 11'h07ff;
    localparam logic [11:0] GAIN_MASK = 12'hfff;
endpackage

// ### src/adc_result_window_correction.sv
`timescale 1ns/10ps
// Operation
// - busy status sets when domain transfer starts
// - busy status clears when transfer is finished
// - result register: sixteen bits, read-only
// - single conversion gives twelve-bit aligned code
// - left align: top eight high, four at [7:4]
// - right align: twelve bits at [11:0]
// - oversampling places full sixteen-bit result
// - lower bound register is window low threshold
// - upper bound register is window high threshold
// - correction enable applies twelve-bit gain factor
// - gain is unsigned 1.11 fixed point
// - correction enable adds two's complement offset
// - result ready set on result, read clears
// - overrun when unread result is overwritten
// - window flag follows matching result by cycle
// - sync done flag on busy falling edge
module adc_result_window_correction
    import adc_result_pkg::*;
(
    input wire logic CLOCK,
    input wire logic RESET_N,
    input wire logic [9:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    // raw converter sample, from the analog domain
    input wire logic SAMPLE_VALID,
    input wire logic [15:0] SAMPLE_CODE,
    output logic IRQ
);
    typedef enum logic [2:0] {
        SY_IDLE = 3'b001,
        SY_XFER = 3'b010,
        SY_DONE = 3'b100
    } sync_state_e;

    sync_state_e sync_r;
    logic [7:0] idx;
    logic acc_r;
    logic rd_hit, wr_hit;
    logic [3:0] ctl_r;
    logic [15:0] win_lo_r, win_hi_r, win_lo_cv_r, win_hi_cv_r;
    logic [11:0] gain_r, offs_r;
    logic [10:0] trim_r;
    logic [15:0] result_r;
    logic [IRQ_BITS-1:0] flags_r, enable_r;
    logic unread_r;
    logic win_hit_r;
    logic [2:0] vld_sync_r;
    logic [15:0] code_s1_r, code_s2_r;
    logic sample_evt;
    logic [24:0] gain_prod;
    logic signed [14:0] corr_sum;
    logic [11:0] corr_code;
    logic [15:0] aligned;
    logic [IRQ_BITS-1:0] set_v, clr_v;
    logic result_read;

    assign idx = AVS_ADDRESS[9:2];
    assign rd_hit = AVS_READ && !acc_r;
    assign wr_hit = AVS_WRITE && !acc_r;
    assign result_read = rd_hit && idx == IDX_CONVERSION_RESULT;

    // one wait cycle per access keeps the read data a registered value
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            acc_r <= 1'b0;
        end else begin
            acc_r <= (AVS_READ || AVS_WRITE) && !acc_r;
        end
    end

    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            AVS_WAITREQUEST <= 1'b1;
        end else begin
            AVS_WAITREQUEST <= !((AVS_READ || AVS_WRITE) && !acc_r);
        end
    end

    // control, correction and window registers, written only when both low byte lanes are enabled
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            ctl_r <= 4'h0;
            gain_r <= RESET_VALUE_16[11:0];
            offs_r <= RESET_VALUE_16[11:0];
            trim_r <= RESET_VALUE_16[10:0];
            win_lo_r <= RESET_VALUE_16;
            win_hi_r <= RESET_VALUE_16;
        end else if (wr_hit && AVS_BYTEENABLE[1:0] == 2'b11) begin
            unique case (idx)
                IDX_CONTROL: ctl_r <= AVS_WRITEDATA[3:0];
                IDX_GAIN_FACTOR: gain_r <= AVS_WRITEDATA[11:0] & GAIN_MASK;
                IDX_OFFSET_VALUE: offs_r <= AVS_WRITEDATA[11:0];
                // low eleven bits stored as written, upper bits dropped
                IDX_ANALOG_TRIM: trim_r <= AVS_WRITEDATA[10:0] & TRIM_MASK;
                IDX_WINDOW_LOWER: win_lo_r <= AVS_WRITEDATA[15:0];
                IDX_WINDOW_UPPER: win_hi_r <= AVS_WRITEDATA[15:0];
                default: ;
            endcase
        end
    end

    // threshold transfer into the converter side, busy while it runs
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            sync_r <= SY_IDLE;
        end else begin
            unique case (sync_r)
                SY_IDLE: if (wr_hit && (idx == IDX_WINDOW_LOWER ||
                        idx == IDX_WINDOW_UPPER)) begin
                    sync_r <= SY_XFER;
                end
                SY_XFER: sync_r <= SY_DONE;
                SY_DONE: sync_r <= SY_IDLE;
            endcase
        end
    end

    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            win_lo_cv_r <= RESET_VALUE_16;
            win_hi_cv_r <= RESET_VALUE_16;
        end else if (sync_r == SY_XFER) begin
            win_lo_cv_r <= win_lo_r;
            win_hi_cv_r <= win_hi_r;
        end
    end

    // sample valid is a level toggle-free strobe: two flops then edge
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            vld_sync_r <= 3'b000;
            code_s1_r <= RESET_VALUE_16;
            code_s2_r <= RESET_VALUE_16;
        end else begin
            vld_sync_r <= {vld_sync_r[1:0], SAMPLE_VALID};
            code_s1_r <= SAMPLE_CODE;
            code_s2_r <= code_s1_r;
        end
    end
    assign sample_evt = vld_sync_r[1] && !vld_sync_r[2];

    // gain in 1.11 format, then signed offset, clamped to 12 bits
    // the scaled code keeps thirteen bits: a gain near two on a large
    // code must still reach the clamp instead of wrapping
    assign gain_prod = 25'(code_s2_r[11:0] * gain_r);
    assign corr_sum = 15'($signed({2'b00, gain_prod[23:GAIN_FRAC_BITS]})
        + $signed({{3{offs_r[11]}}, offs_r}));
    always_comb begin
        if (corr_sum < 0) begin
            corr_code = 12'h000;
        end else if (corr_sum > 15'sh0fff) begin
            corr_code = 12'hfff;
        end else begin
            corr_code = corr_sum[11:0];
        end
    end

    always_comb begin
        logic [11:0] c;
        c = ctl_r[CTL_CORR_EN] ? corr_code : code_s2_r[11:0];
        if (ctl_r[CTL_OVERSAMPLE]) begin
            aligned = code_s2_r;
        end else if (ctl_r[CTL_LEFT_ALIGN]) begin
            aligned = {c, 4'h0};
        end else begin
            aligned = {4'h0, c};
        end
    end

    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            result_r <= RESET_VALUE_16;
        end else if (sample_evt) begin
            result_r <= aligned;
        end
    end

    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            unread_r <= 1'b0;
        end else if (sample_evt) begin
            unread_r <= 1'b1;
        end else if (result_read) begin
            unread_r <= 1'b0;
        end
    end

    // compare the result as it is stored, flag one cycle later
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            win_hit_r <= 1'b0;
        end else begin
            win_hit_r <= sample_evt && ctl_r[CTL_WIN_EN]
                && aligned >= win_lo_cv_r
                && aligned <= win_hi_cv_r;
        end
    end

    always_comb begin
        set_v = '0;
        set_v[IRQ_RESULT_READY_FLAG] = sample_evt;
        set_v[IRQ_OVERRUN] = sample_evt && unread_r;
        set_v[IRQ_WINDOW] = win_hit_r;
        set_v[IRQ_SYNC] = sync_r == SY_DONE;
        clr_v = '0;
        if (wr_hit && idx == IDX_IRQ_FLAGS) begin
            clr_v = AVS_WRITEDATA[IRQ_BITS-1:0];
        end
        if (result_read) begin
            clr_v[IRQ_RESULT_READY_FLAG] = 1'b1;
            clr_v[IRQ_WINDOW] = 1'b1;
        end
    end

    // set wins over clear in the same cycle
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            flags_r <= '0;
        end else begin
            flags_r <= (flags_r & ~clr_v) | set_v;
        end
    end

    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            enable_r <= '0;
        end else if (wr_hit && idx == IDX_IRQ_ENABLE) begin
            enable_r <= enable_r | AVS_WRITEDATA[IRQ_BITS-1:0];
        end else if (wr_hit && idx == IDX_IRQ_CLEAR) begin
            enable_r <= enable_r & ~AVS_WRITEDATA[IRQ_BITS-1:0];
        end
    end

    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            IRQ <= 1'b0;
        end else begin
            IRQ <= |(((flags_r & ~clr_v) | set_v) & enable_r);
        end
    end

    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            AVS_READDATA <= 32'h0000_0000;
        end else if (rd_hit) begin
            unique case (idx)
                IDX_CONTROL: AVS_READDATA <= {28'h000_0000, ctl_r};
                IDX_IRQ_CLEAR,
                IDX_IRQ_ENABLE: AVS_READDATA <= {28'h000_0000, enable_r};
                IDX_IRQ_FLAGS: AVS_READDATA <= {28'h000_0000, flags_r};
                IDX_SYNC_STATUS: AVS_READDATA <= {24'h00_0000,
                    sync_r != SY_IDLE, 7'h00};
                IDX_CONVERSION_RESULT: AVS_READDATA <= {16'h0000, result_r};
                IDX_WINDOW_LOWER: AVS_READDATA <= {16'h0000, win_lo_r};
                IDX_WINDOW_UPPER: AVS_READDATA <= {16'h0000, win_hi_r};
                IDX_GAIN_FACTOR: AVS_READDATA <= {20'h0_0000, gain_r};
                IDX_OFFSET_VALUE: AVS_READDATA <= {20'h0_0000, offs_r};
                IDX_ANALOG_TRIM: AVS_READDATA <= {21'h00_0000, trim_r};
                default: AVS_READDATA <= 32'h0000_0000;
            endcase
        end
    end

    sequence thr_write_s;
        wr_hit && (idx == IDX_WINDOW_LOWER || idx == IDX_WINDOW_UPPER)
            && sync_r == SY_IDLE;
    endsequence
    sequence busy_two_s;
        (sync_r != SY_IDLE) [*2] ##1 (sync_r == SY_IDLE);
    endsequence

    busy_sets_a: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        thr_write_s |=> busy_two_s)
        else $error("busy status did not run two cycles");
    busy_clears_a: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        sync_r == SY_DONE |=> sync_r == SY_IDLE)
        else $error("busy status stuck");
    sync_done_a: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        sync_r == SY_DONE |=> flags_r[IRQ_SYNC])
        else $error("sync done flag missing");
    result_ready_flag_set_a: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        sample_evt |=> flags_r[IRQ_RESULT_READY_FLAG] && result_r == $past(aligned))
        else $error("result ready or result wrong");
    overrun_set_a: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        sample_evt && unread_r |=> flags_r[IRQ_OVERRUN])
        else $error("overrun not flagged");
    right_align_a: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        !ctl_r[CTL_LEFT_ALIGN] && !ctl_r[CTL_OVERSAMPLE]
            |-> aligned[15:12] == 4'h0)
        else $error("right aligned result has high bits");
    left_align_a: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        ctl_r[CTL_LEFT_ALIGN] && !ctl_r[CTL_OVERSAMPLE]
            |-> aligned[3:0] == 4'h0)
        else $error("left aligned result has low bits");
    window_flag_a: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        sample_evt && ctl_r[CTL_WIN_EN] && aligned >= win_lo_cv_r
            && aligned <= win_hi_cv_r |=> ##1 flags_r[IRQ_WINDOW])
        else $error("window match not flagged");
    no_corr_a: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        !ctl_r[CTL_CORR_EN] && !ctl_r[CTL_OVERSAMPLE]
            && !ctl_r[CTL_LEFT_ALIGN] |-> aligned[11:0] == code_s2_r[11:0])
        else $error("code changed without correction");

    // the status bit a read returns is the busy state at the access edge
    busy_read_a: assert property (
        @(posedge CLOCK) disable iff (!RESET_N)
        rd_hit && idx == IDX_SYNC_STATUS
            |=> AVS_READDATA[SYNC_BUSY_BIT] == $past(sync_r != SY_IDLE))
        else $error("busy status read back wrong");

    thr_copy_a: assert property (
        @(posedge CLOCK) disable iff (!RESET_N)
        sync_r == SY_XFER |=> win_lo_cv_r == $past(win_lo_r)
            && win_hi_cv_r == $past(win_hi_r))
        else $error("thresholds not copied to converter side");

    result_hold_a: assert property (
        @(posedge CLOCK) disable iff (!RESET_N)
        !sample_evt |=> $stable(result_r))
        else $error("result changed without a sample");

    oversample_pass_a: assert property (
        @(posedge CLOCK) disable iff (!RESET_N)
        ctl_r[CTL_OVERSAMPLE] |-> aligned == code_s2_r)
        else $error("oversampled result not passed whole");

    // unity gain with no offset must leave the code untouched
    gain_unity_a: assert property (
        @(posedge CLOCK) disable iff (!RESET_N)
        gain_r == 12'h800 && offs_r == 12'h000
            |-> corr_code == code_s2_r[11:0])
        else $error("unity gain changed the code");

    clamp_high_a: assert property (
        @(posedge CLOCK) disable iff (!RESET_N)
        corr_sum > 15'sh0fff |-> corr_code == 12'hfff)
        else $error("corrected code not clamped high");

    clamp_low_a: assert property (
        @(posedge CLOCK) disable iff (!RESET_N)
        corr_sum < 0 |-> corr_code == 12'h000)
        else $error("corrected code not clamped low");

    result_ready_flag_clear_a: assert property (
        @(posedge CLOCK) disable iff (!RESET_N)
        result_read && !sample_evt |=> !flags_r[IRQ_RESULT_READY_FLAG])
        else $error("result read did not clear ready flag");

    overrun_quiet_a: assert property (
        @(posedge CLOCK) disable iff (!RESET_N)
        sample_evt && !unread_r && !flags_r[IRQ_OVERRUN]
            |=> !flags_r[IRQ_OVERRUN])
        else $error("overrun flagged without lost result");

    window_miss_a: assert property (
        @(posedge CLOCK) disable iff (!RESET_N)
        sample_evt && (aligned < win_lo_cv_r || aligned > win_hi_cv_r)
            |=> !win_hit_r)
        else $error("window match outside thresholds");
endmodule

// ### tb/sample_source.sv
`timescale 1ns/10ps
// converter side; the code goes stale after valid falls so that a late
// capture in the design shows up as a wrong result
module sample_source (
    input wire logic clk,
    output logic sample_valid,
    output logic [15:0] sample_code
);
    initial begin
        sample_valid = 1'b0;
        sample_code = 16'h0000;
    end

    task automatic send(input logic [15:0] code);
        @(posedge clk);
        sample_code <= code;
        repeat (3) @(posedge clk);
        sample_valid <= 1'b1;
        repeat (4) @(posedge clk);
        sample_valid <= 1'b0;
        repeat (2) @(posedge clk);
        sample_code <= ~code;
        repeat (4) @(posedge clk);
    endtask
endmodule

// ### tb/tb_top.sv
`timescale 1ns/10ps
module tb_top import adc_result_pkg::*;;
    typedef struct {
        logic [7:0] ctl;
        logic [15:0] gain;
        logic [15:0] offs;
        logic [15:0] code;
        logic [15:0] res;
    } row_s;
    logic clock, reset_n, rd_req, wr_req, wait_req, irq, s_valid;
    logic [9:0] addr;
    logic [31:0] wdata, rdata, rd;
    logic [3:0] byte_en;
    logic [15:0] s_code;
    int n_mismatch = 0;
    int num_checks = 0;
    logic [7:0] regs [8] = '{IDX_SYNC_STATUS, IDX_CONVERSION_RESULT,
        IDX_WINDOW_LOWER, IDX_WINDOW_UPPER, IDX_GAIN_FACTOR,
        IDX_OFFSET_VALUE, IDX_ANALOG_TRIM, IDX_IRQ_FLAGS};
    // gain 16'h0800 is unity; the last row drives the clamp
    row_s rows [6] = '{
        '{8'h00, 16'h0000, 16'h0000, 16'h0abc, 16'h0abc},
        '{8'h01, 16'h0000, 16'h0000, 16'h0abc, 16'habc0},
        '{8'h08, 16'h0000, 16'h0000, 16'h1234, 16'h1234},
        '{8'h02, 16'h0800, 16'h0010, 16'h0100, 16'h0110},
        '{8'h02, 16'h0400, 16'h0fff, 16'h0200, 16'h00ff},
        '{8'h02, 16'h0fff, 16'h0000, 16'h0fff, 16'h0fff}};

    adc_result_window_correction u_adc_result_window_correction (
        .CLOCK(clock), .RESET_N(reset_n), .AVS_ADDRESS(addr),
        .AVS_READ(rd_req), .AVS_WRITE(wr_req), .AVS_WRITEDATA(wdata),
        .AVS_BYTEENABLE(byte_en), .AVS_READDATA(rdata),
        .AVS_WAITREQUEST(wait_req), .SAMPLE_VALID(s_valid),
        .SAMPLE_CODE(s_code), .IRQ(irq));
    sample_source u_sample_source (
        .clk(clock), .sample_valid(s_valid), .sample_code(s_code));

    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic summarize();
        $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // the request stands until the edge where waitrequest is sampled low
    task automatic bus(input logic wr, input logic [7:0] idx,
                       input logic [31:0] wd);
        int n;
        @(posedge clock);
        addr <= {idx, 2'b00};
        rd_req <= !wr;
        wr_req <= wr;
        wdata <= wd;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (wait_req !== 1'b0 && n < 20);
        if (n >= 20) begin
            n_mismatch++;
        end
        rd = rdata;
        rd_req <= 1'b0;
        wr_req <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
        bus(1'b1, idx, wd);
    endtask

    task automatic rdc(input logic [7:0] idx, input logic [31:0] exp);
        bus(1'b0, idx, 32'h0000_0000);
        check(rd, exp);
    endtask

    task automatic wait_sync();
        int n;
        n = 0;
        do begin
            bus(1'b0, IDX_SYNC_STATUS, 32'h0000_0000);
            n++;
        end while (rd[SYNC_BUSY_BIT] !== 1'b0 && n < 20);
        check({31'h0, rd[SYNC_BUSY_BIT]}, 32'h0000_0000);
    endtask

    initial begin
        #100000;
        n_mismatch++;
        summarize();
    end

    initial begin
        reset_n = 1'b0;
        rd_req = 1'b0;
        wr_req = 1'b0;
        addr = 10'h000;
        wdata = 32'h0000_0000;
        byte_en = 4'hf;
        repeat (20) @(posedge clock);
        reset_n <= 1'b1;
        check({31'h0, irq}, 32'h0000_0000);
        foreach (regs[i]) begin
            rdc(regs[i], 32'h0000_0000);
        end
        $display("test reset done");
        wr(IDX_ANALOG_TRIM, 32'h0000_ffff);
        rdc(IDX_ANALOG_TRIM, {21'h0, TRIM_MASK});
        wr(IDX_GAIN_FACTOR, 32'h0000_ffff);
        rdc(IDX_GAIN_FACTOR, {20'h0, GAIN_MASK});
        byte_en <= 4'h1;
        wr(IDX_GAIN_FACTOR, 32'h0000_0000);
        byte_en <= 4'hf;
        rdc(IDX_GAIN_FACTOR, {20'h0, GAIN_MASK});
        wr(8'h3f, 32'hffff_ffff);
        rdc(8'h3f, 32'h0000_0000);
        $display("test registers done");
        foreach (rows[i]) begin
            wr(IDX_GAIN_FACTOR, {16'h0, rows[i].gain});
            wr(IDX_OFFSET_VALUE, {16'h0, rows[i].offs});
            wr(IDX_CONTROL, {24'h0, rows[i].ctl});
            u_sample_source.send(rows[i].code);
            rdc(IDX_IRQ_FLAGS, 32'h0000_0001);
            rdc(IDX_CONVERSION_RESULT, {16'h0, rows[i].res});
            rdc(IDX_IRQ_FLAGS, 32'h0000_0000);
            $display("test row %0d done", i);
        end
        wr(IDX_CONVERSION_RESULT, 32'h0000_1111);
        rdc(IDX_CONVERSION_RESULT, 32'h0000_0fff);
        wr(IDX_WINDOW_LOWER, 32'h0000_0100);
        wait_sync();
        wr(IDX_WINDOW_UPPER, 32'h0000_0200);
        wait_sync();
        rdc(IDX_IRQ_FLAGS, 32'h0000_0008);
        wr(IDX_IRQ_FLAGS, 32'h0000_000f);
        wr(IDX_CONTROL, 32'h0000_0004);
        u_sample_source.send(16'h0100);
        rdc(IDX_IRQ_FLAGS, 32'h0000_0005);
        rdc(IDX_CONVERSION_RESULT, 32'h0000_0100);
        u_sample_source.send(16'h0200);
        rdc(IDX_IRQ_FLAGS, 32'h0000_0005);
        rdc(IDX_CONVERSION_RESULT, 32'h0000_0200);
        u_sample_source.send(16'h0201);
        rdc(IDX_IRQ_FLAGS, 32'h0000_0001);
        // left unread on purpose, so the next result overruns it
        u_sample_source.send(16'h00ff);
        rdc(IDX_IRQ_FLAGS, 32'h0000_0003);
        $display("test window done");
        wr(IDX_IRQ_ENABLE, 32'h0000_0002);
        repeat (2) @(posedge clock);
        check({31'h0, irq}, 32'h0000_0001);
        wr(IDX_IRQ_CLEAR, 32'h0000_0002);
        repeat (2) @(posedge clock);
        check({31'h0, irq}, 32'h0000_0000);
        wr(IDX_IRQ_ENABLE, 32'h0000_0002);
        wr(IDX_IRQ_FLAGS, 32'h0000_000f);
        repeat (2) @(posedge clock);
        check({31'h0, irq}, 32'h0000_0000);
        $display("test interrupt done");
        summarize();
    end
endmodule
